// [hdl/usb_pkg.sv]
// Purpose: constants for the shadow receive/transmit byte alias of the second serial port
// Assumes: one clock (ref_clk, 40 MHz), synchronous active-high reset
// Notes:   register offsets are byte addresses on a plain strobe port
//
// Overview of operation
// - alias sits in one word-sized location
// - read returns byte from serial or infrared
// - fifo off: unread byte overwritten, overrun
// - fifo on: read pops receive fifo head
// - full receive fifo keeps entries, drops new
// - dropped character also flags overrun
// - written byte sent on serial or infrared
// - fifo off: one write clears empty flag
// - fifo off: further writes overwrite pending
// - fifo on: sixteen writes fill fifo
// - write to full transmit fifo is dropped
package usb_pkg;

  // ---------------------------------------------------------------
  // register map
  // ---------------------------------------------------------------
  localparam logic [31:0] USB_ALIAS_OFFSET = 32'h5000_1140; // shadow byte alias
  localparam logic [31:0] USB_CTRL_OFFSET  = 32'h5000_1180; // control: fifo enable, ir mode
  localparam logic [31:0] USB_STAT_OFFSET  = 32'h5000_1184; // line status
  localparam logic [31:0] USB_IRQS_OFFSET  = 32'h5000_1188; // sticky events, write one clears
  localparam logic [31:0] USB_MASK_OFFSET  = 32'h5000_118c; // interrupt mask

  // ---------------------------------------------------------------
  // field positions
  // ---------------------------------------------------------------
  localparam int USB_CTRL_FIFO_EN_BIT = 0; // fifo enable
  localparam int USB_CTRL_IR_MODE_BIT = 1; // infrared mode
  localparam int USB_STAT_READY_BIT   = 0; // receive data ready
  localparam int USB_STAT_OE_BIT      = 1; // overrun seen
  localparam int USB_STAT_HOLD_EMPTY_BIT = 5; // transmit holding empty
  localparam int USB_STAT_TEMT_BIT    = 6; // transmitter idle
  localparam int USB_EV_OVERRUN_BIT   = 0; // event: overrun
  localparam int USB_EV_RX_BIT        = 1; // event: character received
  localparam int USB_EV_HOLD_EMPTY_BIT = 2; // event: holding empty rose

  // ---------------------------------------------------------------
  // widths, depths, resets, timing
  // ---------------------------------------------------------------
  localparam int          USB_FIFO_DEPTH = 16;          // characters per fifo
  localparam int          USB_PTR_W      = 4;           // fifo pointer width
  localparam logic [15:0] USB_ALIAS_RST  = 16'h0000;    // alias reset value
  localparam logic [1:0]  USB_CTRL_RST   = 2'h0;        // fifo off, serial mode
  localparam logic [2:0]  USB_MASK_RST   = 3'h0;        // all events masked
  localparam int          USB_CLK_HZ     = 40_000_000;  // ref_clk rate
  localparam int          USB_BAUD       = 1_000_000;   // line bit rate
  localparam int          USB_BIT_CYC    = USB_CLK_HZ / USB_BAUD; // cycles per bit
  localparam int          USB_IR_CYC     = (USB_BIT_CYC * 3) / 16; // infrared pulse width

  // ---------------------------------------------------------------
  // line engine states
  // ---------------------------------------------------------------
  typedef enum logic [1:0] {USB_IDLE, USB_START, USB_DATA, USB_STOP} usb_line_e;

endpackage : usb_pkg

// [hdl/usb_fifo_mem.sv]
// Purpose: sixteen by eight storage for one character fifo
// Assumes: one write port, one read port, registered read data
// Notes:   no reset on the array, read data reset to zero
`timescale 1ns/1ps
`default_nettype none
module usb_fifo_mem (
  input  wire logic                       ref_clk,  // clock
  input  wire logic                       rst,      // sync reset
  input  wire logic                       wr_en,    // write strobe
  input  wire logic [usb_pkg::USB_PTR_W-1:0] wr_addr, // write address
  input  wire logic [7:0]                 wr_data,  // write data
  input  wire logic [usb_pkg::USB_PTR_W-1:0] rd_addr, // read address
  output logic      [7:0]                 rd_data   // registered read data
);

  // ---------------------------------------------------------------
  // storage
  // ---------------------------------------------------------------
  logic [7:0] mem_q [usb_pkg::USB_FIFO_DEPTH]; // character array

  // write and registered read
  always_ff @(posedge ref_clk) begin
    if (wr_en) begin
      mem_q[wr_addr] <= wr_data;
    end
    if (rst) begin
      rd_data <= 8'h00;
    end else begin
      rd_data <= mem_q[rd_addr];
    end
  end

endmodule : usb_fifo_mem // usb_fifo_mem
`default_nettype wire

// [hdl/usb_shadow_byte.sv]
// Purpose: shadow receive/transmit byte alias with line engines and fifos
// Assumes: pins ser_in and ir_in are asynchronous and synchronised here
// Notes:   fifo memories: rx in usb_fifo_mem, tx kept as flops
//
// Local design decision: the strobed register port.
`timescale 1ns/1ps
`default_nettype none
module usb_shadow_byte (
  input  wire logic        ref_clk,     // 40 MHz clock
  input  wire logic        rst,         // sync reset, active high
  input  wire logic [31:0] bus_addr,    // byte address
  input  wire logic [31:0] bus_wdata,   // write data
  input  wire logic        bus_wr,      // write strobe
  input  wire logic        bus_rd,      // read strobe
  output logic      [31:0] bus_rdata,   // read data, cycle after strobe
  input  wire logic        ser_in,      // serial receive pin
  input  wire logic        ir_in,       // infrared receive pin
  output logic             ser_out,     // serial transmit pin
  output logic             ir_out_n,    // infrared transmit pin, active low
  output logic             irq          // level interrupt
);

  // ---------------------------------------------------------------
  // state
  // ---------------------------------------------------------------
  localparam int PW = usb_pkg::USB_PTR_W;

  typedef struct packed {
    logic [1:0]  sync_a;      // first synchroniser stage (ser, ir)
    logic [1:0]  sync_b;      // second stage
    logic [1:0]  ctrl;        // fifo enable, ir mode
    logic [2:0]  mask;        // interrupt mask
    logic [2:0]  ev;          // sticky events
    logic [31:0] rdata;       // read data register
    logic        rd_sel_fifo; // last read came from rx fifo
    logic [7:0]  rx_buf;      // single receive buffer
    logic        rx_ready;    // data ready (non-fifo)
    logic [7:0]  ir_hold;     // infrared zero bit stretch
    logic        oe;          // overrun status
    logic [PW:0] rx_cnt;      // rx fifo level
    logic [PW-1:0] rx_wp;     // rx write pointer
    logic [PW-1:0] rx_rp;     // rx read pointer
    usb_pkg::usb_line_e rx_st; // receiver state
    logic [7:0]  rx_sh;       // receiver shift
    logic [2:0]  rx_bit;      // receiver bit index
    logic [7:0]  rx_tc;       // receiver tick counter
    logic [127:0] tx_mem;     // tx fifo storage
    logic [PW:0] tx_cnt;      // tx fifo level (holding holds one when fifo off)
    logic [PW-1:0] tx_wp;     // tx write pointer
    logic [PW-1:0] tx_rp;     // tx read pointer
    usb_pkg::usb_line_e tx_st; // transmitter state
    logic [7:0]  tx_sh;       // transmit shift
    logic [2:0]  tx_bit;      // transmit bit index
    logic [7:0]  tx_tc;       // transmit tick counter
    logic        tx_line;     // current line level
    logic        hold_empty_prev; // previous holding empty
  } usb_state_s;

  usb_state_s s_q, s_d; // registered state and next value

  logic [7:0] rx_head;    // head of rx fifo from memory
  logic       rx_push;    // write into rx memory
  logic [7:0] rx_char;    // character being pushed

  // address match helper used by both strobes
  function automatic logic hit(input logic [31:0] a, input logic [31:0] base);
    return a == base;
  endfunction

  // rx fifo memory, head captured at the edge that takes the read
  usb_fifo_mem u_rx_mem (
    .ref_clk (ref_clk),
    .rst     (rst),
    .wr_en   (rx_push),
    .wr_addr (s_q.rx_wp),
    .wr_data (rx_char),
    .rd_addr (s_q.rx_rp),
    .rd_data (rx_head)
  );

  // ---------------------------------------------------------------
  // next state
  // ---------------------------------------------------------------
  always_comb begin
    logic       fifo_en;     // fifo mode
    logic       ir_mode;     // infrared mode
    logic       rx_pin;      // selected receive line
    logic       rx_done;     // character completed this cycle
    logic       hold_empty;  // transmit holding empty
    logic       alias_rd;    // alias read
    logic       alias_wr;    // alias write
    logic       pop_tx;      // transmitter takes a character
    logic [2:0] set_ev;      // event pulses
    s_d      = s_q;
    rx_push  = 1'b0;
    rx_char  = s_q.rx_sh;
    set_ev   = 3'h0;
    rx_done  = 1'b0;
    pop_tx   = 1'b0;
    rx_pin   = 1'b1;
    hold_empty = (s_q.tx_cnt == '0);
    fifo_en  = s_q.ctrl[usb_pkg::USB_CTRL_FIFO_EN_BIT];
    ir_mode  = s_q.ctrl[usb_pkg::USB_CTRL_IR_MODE_BIT];
    alias_rd = bus_rd && hit(bus_addr, usb_pkg::USB_ALIAS_OFFSET);
    alias_wr = bus_wr && hit(bus_addr, usb_pkg::USB_ALIAS_OFFSET);

    // pin synchronisers
    s_d.sync_a = {ir_in, ser_in};
    s_d.sync_b = s_q.sync_a;
    // infrared zero bits are short high pulses: stretch each past mid-bit
    if (s_q.sync_b[1]) begin
      s_d.ir_hold = 8'(usb_pkg::USB_BIT_CYC / 2);
    end else if (s_q.ir_hold != 8'h00) begin
      s_d.ir_hold = s_q.ir_hold - 8'h01;
    end
    rx_pin = ir_mode ? !(s_q.sync_b[1] || s_q.ir_hold != 8'h00) : s_q.sync_b[0];

    // receiver: start, eight data bits lsb first, stop
    s_d.rx_tc = s_q.rx_tc + 8'h01;
    case (s_q.rx_st)
      usb_pkg::USB_IDLE: begin
        s_d.rx_tc = 8'h00;
        if (!rx_pin) begin
          s_d.rx_st = usb_pkg::USB_START;
        end
      end
      usb_pkg::USB_START: begin
        if (s_q.rx_tc == 8'(usb_pkg::USB_BIT_CYC / 2)) begin
          s_d.rx_tc  = 8'h00;
          s_d.rx_bit = 3'h0;
          s_d.rx_st  = rx_pin ? usb_pkg::USB_IDLE : usb_pkg::USB_DATA;
        end
      end
      usb_pkg::USB_DATA: begin
        if (s_q.rx_tc == 8'(usb_pkg::USB_BIT_CYC - 1)) begin
          s_d.rx_tc  = 8'h00;
          s_d.rx_sh  = {rx_pin, s_q.rx_sh[7:1]};
          s_d.rx_bit = s_q.rx_bit + 3'h1;
          if (s_q.rx_bit == 3'h7) begin
            s_d.rx_st = usb_pkg::USB_STOP;
          end
        end
      end
      usb_pkg::USB_STOP: begin
        if (s_q.rx_tc == 8'(usb_pkg::USB_BIT_CYC - 1)) begin
          rx_done   = 1'b1;
          s_d.rx_st = usb_pkg::USB_IDLE;
        end
      end
      default: s_d.rx_st = usb_pkg::USB_IDLE;
    endcase

    // alias read: capture data, pop fifo
    if (alias_rd && fifo_en && s_q.rx_cnt != '0) begin
      s_d.rx_rp  = s_q.rx_rp + 1'b1;
      s_d.rx_cnt = s_q.rx_cnt - 1'b1;
    end else if (alias_rd && !fifo_en) begin
      s_d.rx_ready = 1'b0;
    end
    // fifo-mode alias reads answer from the memory register
    s_d.rd_sel_fifo = alias_rd && fifo_en;

    // received character lands
    if (rx_done) begin
      set_ev[usb_pkg::USB_EV_RX_BIT] = 1'b1;
      if (fifo_en) begin
        if (s_d.rx_cnt == 5'(usb_pkg::USB_FIFO_DEPTH)) begin
          set_ev[usb_pkg::USB_EV_OVERRUN_BIT] = 1'b1;
        end else begin
          rx_push    = 1'b1;
          s_d.rx_wp  = s_q.rx_wp + 1'b1;
          s_d.rx_cnt = s_d.rx_cnt + 1'b1;
        end
      end else begin
        if (s_d.rx_ready) begin
          set_ev[usb_pkg::USB_EV_OVERRUN_BIT] = 1'b1;
        end
        s_d.rx_buf   = s_q.rx_sh;
        s_d.rx_ready = 1'b1;
      end
    end
    if (set_ev[usb_pkg::USB_EV_OVERRUN_BIT]) begin
      s_d.oe = 1'b1;
    end

    // transmitter engine
    s_d.tx_tc = s_q.tx_tc + 8'h01;
    case (s_q.tx_st)
      usb_pkg::USB_IDLE: begin
        s_d.tx_tc   = 8'h00;
        s_d.tx_line = 1'b1;
        if (s_q.tx_cnt != '0) begin
          pop_tx      = 1'b1;
          s_d.tx_sh   = fifo_en ? s_q.tx_mem[s_q.tx_rp*8 +: 8] : s_q.tx_mem[7:0];
          s_d.tx_line = 1'b0;
          s_d.tx_st   = usb_pkg::USB_START;
        end
      end
      usb_pkg::USB_START: begin
        if (s_q.tx_tc == 8'(usb_pkg::USB_BIT_CYC - 1)) begin
          s_d.tx_tc   = 8'h00;
          s_d.tx_bit  = 3'h0;
          s_d.tx_line = s_q.tx_sh[0];
          s_d.tx_st   = usb_pkg::USB_DATA;
        end
      end
      usb_pkg::USB_DATA: begin
        if (s_q.tx_tc == 8'(usb_pkg::USB_BIT_CYC - 1)) begin
          s_d.tx_tc  = 8'h00;
          s_d.tx_sh  = {1'b1, s_q.tx_sh[7:1]};
          s_d.tx_bit = s_q.tx_bit + 3'h1;
          s_d.tx_line = (s_q.tx_bit == 3'h7) ? 1'b1 : s_q.tx_sh[1];
          if (s_q.tx_bit == 3'h7) begin
            s_d.tx_st = usb_pkg::USB_STOP;
          end
        end
      end
      usb_pkg::USB_STOP: begin
        if (s_q.tx_tc == 8'(usb_pkg::USB_BIT_CYC - 1)) begin
          s_d.tx_st = usb_pkg::USB_IDLE;
        end
      end
      default: s_d.tx_st = usb_pkg::USB_IDLE;
    endcase
    if (pop_tx) begin
      s_d.tx_rp  = fifo_en ? s_q.tx_rp + 1'b1 : s_q.tx_rp;
      s_d.tx_cnt = s_q.tx_cnt - 1'b1;
    end
    // pending write lands after the pop so a same-cycle write is not lost
    if (alias_wr) begin
      if (!fifo_en) begin
        s_d.tx_mem[7:0] = bus_wdata[7:0];
        s_d.tx_cnt      = 5'h01;
      end else if (s_q.tx_cnt != 5'(usb_pkg::USB_FIFO_DEPTH)) begin
        s_d.tx_mem[s_q.tx_wp*8 +: 8] = bus_wdata[7:0];
        s_d.tx_wp  = s_q.tx_wp + 1'b1;
        s_d.tx_cnt = s_d.tx_cnt + 1'b1;
      end
      // full fifo: write dropped, contents untouched
    end
    // rising holding empty raises its event
    s_d.hold_empty_prev = hold_empty;
    if (hold_empty && !s_q.hold_empty_prev) begin
      set_ev[usb_pkg::USB_EV_HOLD_EMPTY_BIT] = 1'b1;
    end

    // control and interrupt registers
    if (bus_wr && hit(bus_addr, usb_pkg::USB_CTRL_OFFSET)) begin
      s_d.ctrl = bus_wdata[1:0];
      if (bus_wdata[0] != fifo_en) begin
        // fifo mode change flushes both queues
        s_d.rx_cnt = '0;
        s_d.rx_wp  = '0;
        s_d.rx_rp  = '0;
        s_d.tx_cnt = '0;
        s_d.tx_wp  = '0;
        s_d.tx_rp  = '0;
      end
    end
    if (bus_wr && hit(bus_addr, usb_pkg::USB_MASK_OFFSET)) begin
      s_d.mask = bus_wdata[2:0];
    end
    // write one clears; a same-cycle event wins
    s_d.ev = s_q.ev;
    if (bus_wr && hit(bus_addr, usb_pkg::USB_IRQS_OFFSET)) begin
      s_d.ev = s_q.ev & ~bus_wdata[2:0];
    end
    s_d.ev = s_d.ev | set_ev;
    // overrun status clears on status read, event wins
    if (bus_rd && hit(bus_addr, usb_pkg::USB_STAT_OFFSET)) begin
      s_d.oe = set_ev[usb_pkg::USB_EV_OVERRUN_BIT];
    end

    // read data: registered at the strobe edge; fifo-mode alias data comes from the memory instead
    s_d.rdata = 32'h0;
    if (bus_rd) begin
      if (hit(bus_addr, usb_pkg::USB_CTRL_OFFSET)) begin
        s_d.rdata[1:0] = s_q.ctrl;
      end else if (hit(bus_addr, usb_pkg::USB_STAT_OFFSET)) begin
        s_d.rdata[usb_pkg::USB_STAT_READY_BIT] =
          fifo_en ? (s_q.rx_cnt != '0) : s_q.rx_ready;
        s_d.rdata[usb_pkg::USB_STAT_OE_BIT] = s_q.oe;
        s_d.rdata[usb_pkg::USB_STAT_HOLD_EMPTY_BIT] = hold_empty;
        s_d.rdata[usb_pkg::USB_STAT_TEMT_BIT] = hold_empty && s_q.tx_st == usb_pkg::USB_IDLE;
      end else if (hit(bus_addr, usb_pkg::USB_IRQS_OFFSET)) begin
        s_d.rdata[2:0] = s_q.ev;
      end else if (hit(bus_addr, usb_pkg::USB_MASK_OFFSET)) begin
        s_d.rdata[2:0] = s_q.mask;
      end else if (alias_rd && !fifo_en) begin
        s_d.rdata[7:0] = s_q.rx_buf;
      end
    end
  end

  // ---------------------------------------------------------------
  // registers
  // ---------------------------------------------------------------
  always_ff @(posedge ref_clk) begin
    if (rst) begin
      s_q        <= '0;
      s_q.sync_a <= 2'h1; // idle levels: serial high, infrared low
      s_q.sync_b <= 2'h1;
      s_q.ctrl   <= usb_pkg::USB_CTRL_RST;
      s_q.mask   <= usb_pkg::USB_MASK_RST;
      s_q.rx_st  <= usb_pkg::USB_IDLE;
      s_q.tx_st  <= usb_pkg::USB_IDLE;
      s_q.tx_line <= 1'b1;
      s_q.hold_empty_prev <= 1'b1;
    end else begin
      s_q <= s_d;
    end
  end

  // ---------------------------------------------------------------
  // outputs
  // ---------------------------------------------------------------
  // fifo-mode alias reads show the fifo head; upper half and word above stay zero
  assign bus_rdata = s_q.rd_sel_fifo ? {24'h0, rx_head} : s_q.rdata;
  // serial output idles high in infrared mode
  assign ser_out  = s_q.ctrl[usb_pkg::USB_CTRL_IR_MODE_BIT] ? 1'b1 : s_q.tx_line;
  // infrared: low pulse for the first part of each zero bit
  assign ir_out_n = !(s_q.ctrl[usb_pkg::USB_CTRL_IR_MODE_BIT] && !s_q.tx_line
                      && s_q.tx_tc < 8'(usb_pkg::USB_IR_CYC));
  assign irq = |(s_q.ev & s_q.mask);

endmodule : usb_shadow_byte // usb_shadow_byte
`default_nettype wire

// [verif/usb_shadow_byte_properties.sv]
// Purpose: port-level checker for the shadow byte alias block
// Assumes: one clock domain, synchronous active-high reset
// Notes:   control and clear writes are tracked from the bus
`timescale 1ns/1ps
`default_nettype none
module usb_shadow_byte_properties (
  input wire logic        ref_clk,
  input wire logic        rst,
  input wire logic [31:0] bus_addr,
  input wire logic [31:0] bus_wdata,
  input wire logic        bus_wr,
  input wire logic        bus_rd,
  input wire logic [31:0] bus_rdata,
  input wire logic        ser_out,
  input wire logic        ir_out_n,
  input wire logic        irq
);
  // ---------------------------------------------------------------
  // helper state
  // ---------------------------------------------------------------
  logic       ir_q;      // infrared mode as last written
  logic [9:0] low_cnt_q; // run of low cycles on the serial output
  logic       clr_q;     // clear or mask write one cycle ago
  logic       clr_now;   // clear or mask write now
  logic       mapped;    // address decodes to a register
  assign clr_now = bus_wr && (bus_addr == usb_pkg::USB_IRQS_OFFSET ||
                              bus_addr == usb_pkg::USB_MASK_OFFSET);
  assign mapped = bus_addr inside {usb_pkg::USB_ALIAS_OFFSET, usb_pkg::USB_CTRL_OFFSET,
                  usb_pkg::USB_STAT_OFFSET, usb_pkg::USB_IRQS_OFFSET, usb_pkg::USB_MASK_OFFSET};
  // track mode, low runs and clear writes
  always_ff @(posedge ref_clk) begin
    if (rst) begin
      ir_q      <= 1'b0;
      low_cnt_q <= 10'h0;
      clr_q     <= 1'b0;
    end else begin
      if (bus_wr && bus_addr == usb_pkg::USB_CTRL_OFFSET) begin
        ir_q <= bus_wdata[usb_pkg::USB_CTRL_IR_MODE_BIT];
      end
      low_cnt_q <= ser_out ? 10'h0 : low_cnt_q + 10'h1;
      clr_q     <= clr_now;
    end
  end
  default clocking @(posedge ref_clk); endclocking
  default disable iff (rst);
  // ---------------------------------------------------------------
  // assertions
  // ---------------------------------------------------------------
  AST_RDATA_IDLE: assert property (!$past(bus_rd) |-> bus_rdata == 32'h0)
    else $error("read data not zero outside the answer cycle");
  AST_UPPER_ZERO: assert property (
    bus_rd && bus_addr == usb_pkg::USB_ALIAS_OFFSET |=> bus_rdata[31:8] == 24'h0)
    else $error("alias upper bits not zero");
  AST_UNMAPPED_ZERO: assert property (bus_rd && !mapped |=> bus_rdata == 32'h0)
    else $error("unmapped read not zero");
  AST_IR_SER_HIGH: assert property (ir_q [*3] |-> ser_out)
    else $error("serial output active in infrared mode");
  AST_SER_IR_IDLE: assert property ((!ir_q) [*3] |-> ir_out_n)
    else $error("infrared output active in serial mode");
  AST_IR_PULSE_W: assert property ($fell(ir_out_n) |-> (!ir_out_n) [*7] ##1 ir_out_n)
    else $error("infrared pulse width wrong");
  AST_BIT_TIME: assert property (
    $rose(ser_out) |-> low_cnt_q % usb_pkg::USB_BIT_CYC == 0)
    else $error("serial low run not whole bits");
  AST_IRQ_HOLD: assert property (irq && !clr_now && !clr_q |=> irq)
    else $error("interrupt dropped without a clear");
  // main scenarios
  cover property (bus_rd && bus_addr == usb_pkg::USB_ALIAS_OFFSET);
  cover property ($fell(ir_out_n));
  cover property ($rose(irq));
endmodule // usb_shadow_byte_properties

bind usb_shadow_byte usb_shadow_byte_properties usb_shadow_byte_properties_inst (
  .ref_clk(ref_clk), .rst(rst), .bus_addr(bus_addr), .bus_wdata(bus_wdata),
  .bus_wr(bus_wr), .bus_rd(bus_rd), .bus_rdata(bus_rdata), .ser_out(ser_out),
  .ir_out_n(ir_out_n), .irq(irq));
`default_nettype wire

// [verif/usb_line_model.sv]
// Purpose: remote serial and infrared transceiver
// Assumes: 8N1, lsb first, bit time from the package
// Notes:   bytes seen on the serial output gather in got_q
`timescale 1ns/1ps
`default_nettype none
module usb_line_model (
  input  wire logic ref_clk,
  input  wire logic ser_out,
  output var  logic ser_in,
  output var  logic ir_in
);
  logic [7:0] got_q [$]; // received bytes, oldest first
  logic [7:0] sh;        // byte being assembled
  initial begin
    ser_in = 1'b1; // serial idles high
    ir_in  = 1'b0; // infrared idles low
  end
  // one frame; a zero bit is a short high pulse on the infrared line
  task automatic send_byte(input logic [7:0] b, input logic ir);
    logic [9:0] f;
    f = {1'b1, b, 1'b0};
    for (int i = 0; i < 10; i++) begin
      @(posedge ref_clk);
      ser_in <= ir | f[i];
      ir_in  <= ir & ~f[i];
      repeat (usb_pkg::USB_IR_CYC) @(posedge ref_clk);
      ir_in <= 1'b0;
      repeat (usb_pkg::USB_BIT_CYC - usb_pkg::USB_IR_CYC - 1) @(posedge ref_clk);
    end
  endtask
  // sample each bit in its middle; frames with a bad stop bit are dropped
  always begin
    @(negedge ser_out);
    repeat (usb_pkg::USB_BIT_CYC / 2) @(posedge ref_clk);
    for (int i = 0; i < 8; i++) begin
      repeat (usb_pkg::USB_BIT_CYC) @(posedge ref_clk);
      sh[i] = ser_out;
    end
    repeat (usb_pkg::USB_BIT_CYC) @(posedge ref_clk);
    if (ser_out === 1'b1) got_q.push_back(sh);
  end
endmodule // usb_line_model
`default_nettype wire

// [verif/test_usb_shadow_byte.sv]
// Purpose: register-level tests of the shadow byte alias
// Assumes: design and line model as instantiated below
// Notes:   frame waits follow from 40 cycles per bit
`timescale 1ns/1ps
`default_nettype none
module test_usb_shadow_byte;
  localparam logic [31:0] A_AL = usb_pkg::USB_ALIAS_OFFSET;
  localparam logic [31:0] A_CT = usb_pkg::USB_CTRL_OFFSET;
  localparam logic [31:0] A_ST = usb_pkg::USB_STAT_OFFSET;
  logic        ref_clk   = 1'b0;
  logic        rst       = 1'b1;
  logic [31:0] bus_addr  = 32'h0;
  logic [31:0] bus_wdata = 32'h0;
  logic        bus_wr    = 1'b0;
  logic        bus_rd    = 1'b0;
  logic [31:0] bus_rdata;
  logic        ser_in, ir_in, ser_out, ir_out_n, irq;
  logic        ir_prev   = 1'b1;
  int          falls     = 0;
  int          err_count = 0;
  int          total_checks = 0;
  always #12.5 ref_clk = ~ref_clk;
  usb_shadow_byte usb_shadow_byte_inst (.ref_clk(ref_clk), .rst(rst), .bus_addr(bus_addr),
    .bus_wdata(bus_wdata), .bus_wr(bus_wr), .bus_rd(bus_rd), .bus_rdata(bus_rdata),
    .ser_in(ser_in), .ir_in(ir_in), .ser_out(ser_out), .ir_out_n(ir_out_n), .irq(irq));
  usb_line_model usb_line_model_inst (.ref_clk(ref_clk), .ser_out(ser_out),
    .ser_in(ser_in), .ir_in(ir_in));
  // count infrared pulses
  always @(posedge ref_clk) begin
    ir_prev <= ir_out_n;
    if (ir_prev && !ir_out_n) falls++;
  end
  // write; with more set the strobe stays up for the next write
  task automatic wr(input logic [31:0] a, input logic [31:0] d, input bit more = 1'b0);
    bus_addr  <= a;
    bus_wdata <= d;
    bus_wr    <= 1'b1;
    @(posedge ref_clk);
    if (!more) begin
      bus_wr <= 1'b0;
      @(posedge ref_clk);
    end
  endtask
  task automatic chk(input string n, input logic [31:0] e, input logic [31:0] g);
    total_checks++;
    if (g !== e) begin
      err_count++;
      $display("BAD %s expected %h seen %h", n, e, g);
    end
  endtask
  // read and compare the bits under m
  task automatic rdc(input string n, input logic [31:0] a, input logic [31:0] e,
                     input logic [31:0] m = 32'hffff_ffff);
    logic [31:0] d;
    bus_addr <= a;
    bus_rd   <= 1'b1;
    @(posedge ref_clk);
    bus_rd <= 1'b0;
    @(negedge ref_clk);
    d = bus_rdata;
    @(posedge ref_clk);
    chk(n, e, d & m);
  endtask
  task automatic complete_run;
    $display("checks %0d mismatches %0d", total_checks, err_count);
    if (err_count == 0 && total_checks > 0) begin
      $display("NO MISMATCHES");
    end else begin
      $display("MISMATCHES SEEN");
    end
    $finish;
  endtask
  // watchdog
  initial begin
    repeat (40000) @(posedge ref_clk);
    err_count++;
    complete_run;
  end
  initial begin
    repeat (4) @(posedge ref_clk);
    rst <= 1'b0;
    @(posedge ref_clk);
    rdc("alias reset", A_AL, 32'h0);
    rdc("unmapped", 32'h5000_1190, 32'h0);
    // serial receive, fifo off, overrun interrupt
    wr(usb_pkg::USB_MASK_OFFSET, 32'h1);
    usb_line_model_inst.send_byte(8'ha5, 1'b0);
    chk("irq masked", 32'h0, {31'h0, irq});
    rdc("ready", A_ST, 32'h1, 32'h1);
    rdc("rx byte", A_AL, 32'ha5);
    usb_line_model_inst.send_byte(8'h3c, 1'b0);
    usb_line_model_inst.send_byte(8'h5a, 1'b0);
    chk("irq overrun", 32'h1, {31'h0, irq});
    rdc("rx newest", A_AL, 32'h5a);
    rdc("overrun", A_ST, 32'h2, 32'h2);
    rdc("events", usb_pkg::USB_IRQS_OFFSET, 32'h3);
    wr(usb_pkg::USB_IRQS_OFFSET, 32'h7);
    @(posedge ref_clk);
    chk("irq cleared", 32'h0, {31'h0, irq});
    $display("test serial receive done");
    // receive fifo filled past full
    wr(A_CT, 32'h1);
    for (int i = 0; i < 17; i++) usb_line_model_inst.send_byte(8'(i + 16), 1'b0);
    rdc("fifo overrun", A_ST, 32'h3, 32'h3);
    for (int i = 0; i < 16; i++) rdc("fifo head", A_AL, 32'(i + 16));
    rdc("fifo drained", A_ST, 32'h0, 32'h1);
    $display("test receive fifo done");
    // transmit, fifo off, overwrite of the pending byte
    wr(A_CT, 32'h0);
    usb_line_model_inst.got_q.delete();
    rdc("holding empty", A_ST, 32'h60, 32'h60);
    wr(A_AL, 32'h11);
    repeat (20) @(posedge ref_clk);
    wr(A_AL, 32'h22, 1'b1);
    wr(A_AL, 32'h33);
    rdc("holding full", A_ST, 32'h0, 32'h20);
    repeat (1000) @(posedge ref_clk);
    chk("tx count", 32'h2, 32'(usb_line_model_inst.got_q.size()));
    chk("tx first", 32'h11, 32'(usb_line_model_inst.got_q[0]));
    chk("tx second", 32'h33, 32'(usb_line_model_inst.got_q[1]));
    $display("test transmit holding done");
    // transmit fifo overfilled back to back
    wr(A_CT, 32'h1);
    usb_line_model_inst.got_q.delete();
    for (int i = 0; i < 18; i++) wr(A_AL, 32'(i + 64), i < 17);
    repeat (7600) @(posedge ref_clk);
    chk("tx fifo count", 32'(usb_pkg::USB_FIFO_DEPTH + 1),
        32'(usb_line_model_inst.got_q.size()));
    for (int i = 0; i < 17; i++) chk("tx fifo byte", 32'(i + 64), 32'(usb_line_model_inst.got_q[i]));
    $display("test transmit fifo done");
    // infrared both ways
    wr(A_CT, 32'h2);
    usb_line_model_inst.got_q.delete();
    wr(A_AL, 32'h0f);
    repeat (480) @(posedge ref_clk);
    chk("ir pulses", 32'h5, 32'(falls));
    chk("serial quiet", 32'h0, 32'(usb_line_model_inst.got_q.size()));
    usb_line_model_inst.send_byte(8'hc3, 1'b1);
    rdc("ir rx byte", A_AL, 32'hc3);
    $display("test infrared done");
    complete_run;
  end
endmodule // test_usb_shadow_byte
`default_nettype wire
